// >>> verilog/opmc_ctrl.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module opmc_ctrl
   import opmc_pkg::*;
(
   input wire logic pclk, // apb clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic opt_fast_start, // startup clock option
   input wire logic opt_crystal, // any crystal mode option
   input wire logic opt_t0_low, // timer0 source option
   input wire logic halt_instr, // halt instruction pulse
   input wire logic irq_enabled, // global interrupt enable
   input wire logic [2:0] timer_run_en, // timer enables 2..0
   input wire opmc_wake_type wake_in, // wake interrupt events
   output opmc_clk_type clk_ctl, // clock and run controls
   output logic [2:0] timer_gate, // timers allowed to count
   output logic wdt_clear, // watchdog counter clear pulse
   output logic wake_vector, // branch to isr pulse
   output logic wake_resume, // continue pulse
   output logic [11:0] vector_addr // isr entry address
);
   opmc_state_type state_q, state_d;
   logic [7:0] ctrl_q;
   logic [7:0] stat_q;
   logic [9:0] wait_q;
   logic [9:0] wake_len_q;
   logic start_q;
   logic irq_q;
   logic wr_ok, rd_ok;
   logic [1:0] sleep_mode_field_w;
   logic halt_req, stby_req, wake_s, wake_h, halt_go;

   function automatic logic bus_hit(input logic [11:0] a);
      bus_hit = (a == OPMC_CTRL_OFS) || (a == OPMC_STAT_OFS) || (a == OPMC_MODE_OFS);
   endfunction : bus_hit

   // states in which instructions execute
   function automatic logic is_run(input opmc_state_type s);
      is_run = (s == OPMC_NORMAL) || (s == OPMC_SLOW);
   endfunction : is_run

   // running mode picked by the clock select bit
   function automatic opmc_state_type run_mode(input logic sel);
      run_mode = sel ? OPMC_NORMAL : OPMC_SLOW;
   endfunction : run_mode

   // bus strobes and request decode
   assign wr_ok = psel && penable && pwrite && bus_hit(paddr);
   assign rd_ok = psel && !penable && !pwrite;
   assign sleep_mode_field_w = pwdata[3:2];
   assign halt_req = halt_instr || (wr_ok && paddr == OPMC_CTRL_OFS && sleep_mode_field_w == OPMC_SLEEP_MODE_FIELD_HALT);
   assign stby_req = wr_ok && paddr == OPMC_CTRL_OFS && sleep_mode_field_w == OPMC_SLEEP_MODE_FIELD_STBY;
   assign wake_s = |{wake_in.timer0, wake_in.timer1, wake_in.timer2, wake_in.wdt, wake_in.portb, wake_in.ext};
   assign wake_h = wake_in.wdt || wake_in.portb || wake_in.ext;
   // halt only taken from a running state, never in the start cycle
   assign halt_go = halt_req && is_run(state_q) && !start_q;

   // apb answer, zero wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !bus_hit(paddr);
         if (rd_ok) begin
            unique case (paddr)
               OPMC_CTRL_OFS: prdata <= {24'h00_0000, ctrl_q};
               OPMC_STAT_OFS: prdata <= {24'h00_0000, stat_q};
               OPMC_MODE_OFS: prdata <= {29'h0000_0000, state_q};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 8'h01;
         start_q <= 1'b1;
      end else begin
         start_q <= 1'b0;
         if (start_q) begin
            ctrl_q[OPMC_SEL_BIT] <= opt_fast_start;
         end else if (wr_ok && paddr == OPMC_CTRL_OFS) begin
            ctrl_q <= {pwdata[7:4], pwdata[3:2], pwdata[1], pwdata[0]};
         end else if (state_q == OPMC_WAKE && state_d != OPMC_WAKE || state_q == OPMC_STBY && wake_s) begin
            ctrl_q[3:2] <= OPMC_SLEEP_MODE_FIELD_ACTIVE;
         end
      end
   end

   // status flags; halt entry sets watchdog flag and clears powerdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= OPMC_STAT_RST;
      end else if (halt_go) begin
         stat_q[OPMC_PD_BIT] <= 1'b0;
         stat_q[OPMC_TO_BIT] <= 1'b1;
      end else if (wr_ok && paddr == OPMC_STAT_OFS) begin
         stat_q <= {pwdata[7:5], stat_q[4:3], pwdata[2:0]};
      end
   end

   // operating mode sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         OPMC_NORMAL, OPMC_SLOW: begin
            if (start_q) state_d = opt_fast_start ? OPMC_NORMAL : OPMC_SLOW;
            else if (halt_req) state_d = OPMC_HALT;
            else if (stby_req) state_d = OPMC_STBY;
            else if (wr_ok && paddr == OPMC_CTRL_OFS) state_d = pwdata[OPMC_SEL_BIT] ? OPMC_NORMAL : OPMC_SLOW;
         end
         OPMC_STBY: begin
            if (wake_s) state_d = ctrl_q[OPMC_SEL_BIT] ? OPMC_NORMAL : OPMC_SLOW;
         end
         OPMC_HALT: begin
            if (wake_h) state_d = OPMC_WAKE;
         end
         OPMC_WAKE: begin
            if (wait_q == 10'h001) state_d = ctrl_q[OPMC_SEL_BIT] ? OPMC_NORMAL : OPMC_SLOW;
         end
         default: state_d = OPMC_NORMAL;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_q <= OPMC_NORMAL;
      else state_q <= state_d;
   end

   // halt wake stabilisation counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wait_q <= 10'h000;
      else if (state_q == OPMC_HALT && wake_h) wait_q <= opt_crystal ? OPMC_WAKE_XT : OPMC_WAKE_RC;
      else if (wait_q != 10'h000) wait_q <= wait_q - 10'h001;
   end

   // check helper: cycles spent settling after a halt wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wake_len_q <= 10'h000;
      else if (state_q != OPMC_WAKE) wake_len_q <= 10'h000;
      else wake_len_q <= wake_len_q + 10'h001;
   end

   // interrupt enable captured at sleep entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_q <= 1'b0;
      else if ((state_q == OPMC_NORMAL || state_q == OPMC_SLOW) && (halt_req || stby_req)) irq_q <= irq_enabled;
   end

   // clock, run and wake outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
         timer_gate <= 3'h0;
         wdt_clear <= 1'b0;
         wake_vector <= 1'b0;
         wake_resume <= 1'b0;
         vector_addr <= 12'h000;
      end else begin
         clk_ctl.high_osc_en <= state_d != OPMC_HALT && !(state_d != OPMC_NORMAL && ctrl_q[OPMC_STP_BIT]);
         clk_ctl.low_osc_en <= state_d != OPMC_HALT;
         clk_ctl.sys_clk_high <= state_d == OPMC_NORMAL || (state_d != OPMC_SLOW && ctrl_q[OPMC_SEL_BIT]);
         clk_ctl.cpu_run <= state_d == OPMC_NORMAL || state_d == OPMC_SLOW;
         clk_ctl.periph_en <= state_d == OPMC_NORMAL || state_d == OPMC_SLOW;
         clk_ctl.timer0_low_clk <= state_d == OPMC_NORMAL && ctrl_q[OPMC_LCK_BIT] && opt_t0_low;
         timer_gate <= (state_d == OPMC_HALT || state_d == OPMC_WAKE) ? 3'h0 : timer_run_en;
         wdt_clear <= halt_go;
         wake_vector <= (state_q == OPMC_STBY || state_q == OPMC_WAKE) && (state_d == OPMC_NORMAL || state_d == OPMC_SLOW) && irq_q;
         wake_resume <= (state_q == OPMC_STBY || state_q == OPMC_WAKE) && (state_d == OPMC_NORMAL || state_d == OPMC_SLOW) && !irq_q;
         vector_addr <= OPMC_ISR_VEC;
      end
   end

   // both oscillators off for every halt cycle
   AST_HALT_OSC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_HALT |-> !clk_ctl.high_osc_en && !clk_ctl.low_osc_en)
      else $error("osc on in halt");

   // halt entry flags and watchdog clear
   AST_HALT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      halt_go |=> !stat_q[OPMC_PD_BIT] && stat_q[OPMC_TO_BIT] && wdt_clear)
      else $error("halt flags");

   // halt left only through its own wake sources
   AST_HALT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == OPMC_HALT && !wake_h) |=> state_q == OPMC_HALT)
      else $error("halt left");

   // standby wake returns at once to the selected mode
   AST_STBY_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == OPMC_STBY && wake_s) |=> state_q == run_mode($past(ctrl_q[OPMC_SEL_BIT])))
      else $error("stby wake");

   // rc wake waits at least eight cycles
   AST_WAKE_RC: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == OPMC_HALT && wake_h && !opt_crystal) |=> (state_q == OPMC_WAKE)[*8])
      else $error("short wake");

   // no execution in standby
   AST_STBY_RUN: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_STBY |=> !clk_ctl.cpu_run || state_q != OPMC_STBY)
      else $error("cpu runs");

   // vector pulse carries the service entry
   AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      wake_vector |-> vector_addr == OPMC_ISR_VEC && !wake_resume)
      else $error("vector");

   // slow mode runs from the low oscillator
   AST_CLK_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_SLOW && $past(state_q) == OPMC_SLOW |-> !clk_ctl.sys_clk_high)
      else $error("slow clk");

   // start mode follows the startup option
   AST_START_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      start_q |=> state_q == run_mode($past(opt_fast_start)) && ctrl_q[OPMC_SEL_BIT] == $past(opt_fast_start))
      else $error("start mode");

   // normal mode clocks
   AST_NORMAL_CLK: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_NORMAL |-> clk_ctl.sys_clk_high && clk_ctl.high_osc_en && clk_ctl.low_osc_en)
      else $error("normal clk");

   // low oscillator runs outside halt
   AST_LOW_RUN: assert property (@(posedge pclk) disable iff (!presetn)
      state_q != OPMC_HALT |-> clk_ctl.low_osc_en)
      else $error("low osc off");

   // execution and peripherals only in running modes
   AST_RUN_CPU: assert property (@(posedge pclk) disable iff (!presetn)
      !start_q |-> clk_ctl.cpu_run == is_run(state_q) && clk_ctl.periph_en == clk_ctl.cpu_run)
      else $error("run enables");

   // halt stops peripherals and timers
   AST_HALT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_HALT |-> !clk_ctl.periph_en && !clk_ctl.cpu_run && timer_gate == 3'h0)
      else $error("halt quiet");

   // enabled timers keep counting in standby
   AST_STBY_TIMERS: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_STBY |-> timer_gate == $past(timer_run_en))
      else $error("stby timers");

   // timer0 low clock needs normal mode, bit and option
   AST_T0_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      clk_ctl.timer0_low_clk |-> state_q == OPMC_NORMAL && $past(ctrl_q[OPMC_LCK_BIT]) && $past(opt_t0_low))
      else $error("t0 low clk");

   // stop bit halts the high oscillator in slow mode
   AST_HOSC_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_SLOW && $past(ctrl_q[OPMC_STP_BIT]) |-> !clk_ctl.high_osc_en)
      else $error("hosc not stopped");

   // slow select alone keeps the high oscillator
   AST_HOSC_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_SLOW && !$past(ctrl_q[OPMC_STP_BIT]) |-> clk_ctl.high_osc_en)
      else $error("hosc stopped");

   // standby carries no settling count
   AST_STBY_NO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_STBY |-> wait_q == 10'h000)
      else $error("stby wait");

   // settling length of a halt wake
   AST_WAKE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_WAKE && state_d != OPMC_WAKE |-> wake_len_q + 10'h001 == (opt_crystal ? OPMC_WAKE_XT : OPMC_WAKE_RC))
      else $error("wake length");

   // settling only follows halt
   AST_WAKE_FROM_HALT: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_WAKE |-> $past(state_q) == OPMC_HALT || $past(state_q) == OPMC_WAKE)
      else $error("wake source");

   // no timers or execution while settling
   AST_WAKE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_WAKE |-> timer_gate == 3'h0 && !clk_ctl.cpu_run)
      else $error("wake gate");

   // sleep field back to active after wake
   AST_WAKE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      is_run(state_q) && ($past(state_q) == OPMC_STBY || $past(state_q) == OPMC_WAKE) |-> ctrl_q[3:2] == OPMC_SLEEP_MODE_FIELD_ACTIVE)
      else $error("sleep field");

   // wake pulses only on return to a running mode
   AST_WAKE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_vector || wake_resume |-> is_run(state_q) && ($past(state_q) == OPMC_STBY || $past(state_q) == OPMC_WAKE))
      else $error("wake pulse");

   // resume only with interrupts masked at entry
   AST_RESUME: assert property (@(posedge pclk) disable iff (!presetn)
      wake_resume |-> !wake_vector && !irq_q)
      else $error("resume");

   // watchdog clear is a single pulse
   AST_WDT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_clear |=> !wdt_clear)
      else $error("wdt pulse");

   // vector is a single pulse
   AST_VEC_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_vector |=> !wake_vector)
      else $error("vector pulse");

   // standby request from a running mode
   AST_STBY_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      is_run(state_q) && !start_q && stby_req && !halt_req |=> state_q == OPMC_STBY)
      else $error("stby entry");

   // halt request from a running mode
   AST_HALT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      halt_go |=> state_q == OPMC_HALT)
      else $error("halt entry");

   // stop bit written together with halt entry
   AST_STOP_HALT: assert property (@(posedge pclk) disable iff (!presetn)
      halt_go && wr_ok && paddr == OPMC_CTRL_OFS |=> ctrl_q[OPMC_STP_BIT] == $past(pwdata[OPMC_STP_BIT]))
      else $error("stop with halt");

   // halt wake settles before resuming
   AST_HALT_TO_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_HALT && wake_h |=> state_q == OPMC_WAKE)
      else $error("halt wake");

   // standby held until a wake source
   AST_STBY_STAYS: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_STBY && !wake_s |=> state_q == OPMC_STBY)
      else $error("stby left");

   // halt wake resumes the selected mode
   AST_RESUME_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == OPMC_WAKE && state_d != OPMC_WAKE |=> state_q == run_mode($past(ctrl_q[OPMC_SEL_BIT])))
      else $error("resume mode");
endmodule : opmc_ctrl

// >>> shared/opmc_pkg.sv
// Operation
// - after reset, start in normal mode if startup option fast, else slow.
// - normal mode clocks system from high oscillator; low oscillator keeps running.
// - control bit 0 low selects low oscillator, high selects high oscillator.
// - sleep field bits 3:2, 10b standby, 01b halt; halt instruction also halts.
// - high_osc_stop bit 1 stops high oscillator; low select alone does not.
// - in normal mode, timer0 takes low clock when bit and option both set.
// - standby stops execution; enabled timers and low oscillator keep running.
// - standby ends on timer, watchdog, port b change or external edge interrupt.
// - wake resumes normal if high_clock_select is 1, else slow.
// - halt entry clears powerdown flag, sets watchdog flag, clears watchdog counter.
// - halt stops execution, all peripherals and both oscillators.
// - halt ends only on watchdog, port b change or external edge interrupt.
// - halt wake waits 512 cycles with crystal modes, otherwise 16.
// - standby wake applies no stabilisation delay.
// - wake with interrupts enabled vectors to address 0x008.
// - wake with interrupts disabled continues at the following instruction.
// - one write changing stop bit and entering halt is accepted.
package opmc_pkg;
   localparam logic [11:0] OPMC_CTRL_OFS = 12'h000;
   localparam logic [11:0] OPMC_STAT_OFS = 12'h004;
   localparam logic [11:0] OPMC_MODE_OFS = 12'h008;
   localparam int OPMC_SEL_BIT = 0;
   localparam int OPMC_STP_BIT = 1;
   localparam int OPMC_LCK_BIT = 4;
   localparam int OPMC_PD_BIT = 3;
   localparam int OPMC_TO_BIT = 4;
   localparam logic [1:0] OPMC_SLEEP_MODE_FIELD_ACTIVE = 2'h0;
   localparam logic [1:0] OPMC_SLEEP_MODE_FIELD_HALT = 2'h1;
   localparam logic [1:0] OPMC_SLEEP_MODE_FIELD_STBY = 2'h2;
   localparam logic [7:0] OPMC_STAT_RST = 8'h18;
   localparam logic [11:0] OPMC_ISR_VEC = 12'h008;
   localparam logic [9:0] OPMC_WAKE_XT = 10'h200;
   localparam logic [9:0] OPMC_WAKE_RC = 10'h010;
   typedef enum logic [2:0] {
      OPMC_NORMAL = 3'b000,
      OPMC_SLOW = 3'b001,
      OPMC_STBY = 3'b011,
      OPMC_HALT = 3'b010,
      OPMC_WAKE = 3'b110
   } opmc_state_type;
   typedef struct packed {
      logic timer0;
      logic timer1;
      logic timer2;
      logic wdt;
      logic portb;
      logic ext;
   } opmc_wake_type;
   typedef struct packed {
      logic high_osc_en;
      logic low_osc_en;
      logic sys_clk_high;
      logic cpu_run;
      logic periph_en;
      logic timer0_low_clk;
   } opmc_clk_type;
endpackage : opmc_pkg

// >>> verif/opmc_ctrl_tb.sv
`timescale 1ns/1ps
module opmc_ctrl_tb;
   import opmc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, wdt_clear, wake_vector, wake_resume, vec_seen, res_seen;
   logic opt_fast_start = 1'b1;
   logic opt_crystal = 1'b0;
   logic opt_t0_low = 1'b1;
   logic halt_instr = 1'b0;
   logic irq_enabled = 1'b1;
   logic [2:0] timer_run_en = 3'h5;
   opmc_wake_type wake_in = '0;
   opmc_clk_type clk_ctl;
   logic [2:0] timer_gate;
   logic [11:0] vector_addr;
   int n_fail = 0;
   int n_compared = 0;
   int n_clr = 0;
   int cyc;
   // free-running bus clock
   always #2 pclk = ~pclk;
   // counts watchdog clear pulses
   always @(posedge pclk) if (wdt_clear === 1'b1) n_clr++;
   opmc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .opt_fast_start(opt_fast_start), .opt_crystal(opt_crystal), .opt_t0_low(opt_t0_low),
      .halt_instr(halt_instr), .irq_enabled(irq_enabled), .timer_run_en(timer_run_en), .wake_in(wake_in),
      .clk_ctl(clk_ctl), .timer_gate(timer_gate), .wdt_clear(wdt_clear), .wake_vector(wake_vector),
      .wake_resume(wake_resume), .vector_addr(vector_addr));
   // compare and count
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one apb transfer, holds request until pready, then lets outputs settle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : apb
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask : rdchk
   // pulse one wake source, count edges until a wake pulse shows
   task automatic wake(input int src, input int lim);
      @(posedge pclk);
      wake_in <= opmc_wake_type'(6'h20 >> src);
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
         wake_in <= '0;
         vec_seen = (wake_vector === 1'b1);
         res_seen = (wake_resume === 1'b1);
      end while (!vec_seen && !res_seen && cyc < lim);
   endtask : wake
   task automatic conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // hang guard
   initial begin
      #40000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_NORMAL));
      rdchk("ctrl", OPMC_CTRL_OFS, 32'h01);
      rdchk("stat", OPMC_STAT_OFS, 32'(OPMC_STAT_RST));
      check("sysclk", 1, clk_ctl.sys_clk_high);
      check("losc", 1, clk_ctl.low_osc_en);
      $display("test reset done");
      apb(1'b1, OPMC_CTRL_OFS, 32'h00);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_SLOW));
      check("sysclk", 0, clk_ctl.sys_clk_high);
      check("hosc", 1, clk_ctl.high_osc_en);
      apb(1'b1, OPMC_CTRL_OFS, 32'h02);
      check("hosc", 0, clk_ctl.high_osc_en);
      apb(1'b1, OPMC_CTRL_OFS, 32'h11);
      check("t0low", 1, clk_ctl.timer0_low_clk);
      apb(1'b1, OPMC_CTRL_OFS, 32'h01);
      check("t0low", 0, clk_ctl.timer0_low_clk);
      $display("test clock select done");
      for (int s = 0; s < 6; s++) begin
         apb(1'b1, OPMC_CTRL_OFS, 32'h09);
         rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_STBY));
         check("cpurun", 0, clk_ctl.cpu_run);
         check("tgate", 32'h5, timer_gate);
         check("losc", 1, clk_ctl.low_osc_en);
         wake(s, 40);
         check("vector", 1, vec_seen);
         check("nodelay", 1, cyc <= 4);
         check("vaddr", 32'h008, vector_addr);
         rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_NORMAL));
         rdchk("ctrl", OPMC_CTRL_OFS, 32'h01);
      end
      $display("test standby done");
      irq_enabled <= 1'b0;
      cyc = n_clr;
      apb(1'b1, OPMC_CTRL_OFS, 32'h05);
      check("wdtclr", cyc + 1, n_clr);
      rdchk("stat", OPMC_STAT_OFS, 32'h10);
      check("oscs", 0, {clk_ctl.high_osc_en, clk_ctl.low_osc_en, clk_ctl.periph_en, clk_ctl.cpu_run});
      for (int s = 0; s < 3; s++) begin
         wake(s, 40);
         check("nowake", 0, vec_seen | res_seen);
      end
      wake(3, 40);
      check("resume", 1, res_seen);
      check("rcwait", 1, cyc >= 16 && cyc <= 22);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_NORMAL));
      $display("test halt done");
      opt_crystal <= 1'b1;
      apb(1'b1, OPMC_CTRL_OFS, 32'h00);
      apb(1'b1, OPMC_CTRL_OFS, 32'h06);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_HALT));
      wake(4, 600);
      check("xtwait", 1, cyc >= 512 && cyc <= 518);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_SLOW));
      rdchk("ctrl", OPMC_CTRL_OFS, 32'h02);
      @(posedge pclk);
      halt_instr <= 1'b1;
      @(posedge pclk);
      halt_instr <= 1'b0;
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_HALT));
      wake(5, 600);
      check("resume", 1, res_seen);
      $display("test crystal halt done");
      apb(1'b1, OPMC_CTRL_OFS, 32'h0A);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_STBY));
      check("hosc", 0, clk_ctl.high_osc_en);
      check("sysclk", 0, clk_ctl.sys_clk_high);
      wake(0, 40);
      check("resume", 1, res_seen);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_SLOW));
      $display("test standby stop done");
      apb(1'b1, 12'h00C, 32'hFF);
      check("slverr", 1, err);
      rdchk("ctrl", OPMC_CTRL_OFS, 32'h02);
      $display("test unmapped done");
      opt_fast_start <= 1'b0;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdchk("mode", OPMC_MODE_OFS, 32'(OPMC_SLOW));
      rdchk("ctrl", OPMC_CTRL_OFS, 32'h00);
      check("sysclk", 0, clk_ctl.sys_clk_high);
      $display("test slow start done");
      conclude();
   end
endmodule : opmc_ctrl_tb
